// >>> rtl/i2c_status_pkg.sv
// Constants, register map and state types of the two-wire status and data register block.
// Assumes a 32-bit APB slave port on core_clk and bus pins sampled from outside that domain.
package i2c_status_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h18;
	localparam logic [7:0] OFF_CLEAR    = 8'h1C;
	localparam logic [7:0] OFF_CRC      = 8'h20;
	localparam logic [7:0] OFF_RXDATA   = 8'h24;
	localparam logic [7:0] OFF_TXDATA   = 8'h28;
	localparam logic [7:0] OFF_IRQ_ST   = 8'h30;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
	localparam logic [7:0] OFF_ADDRMASK = 8'h90;

	// Flag positions in status_flags, irq status and irq mask.
	localparam int F_TXE   = 0;
	localparam int F_TXREQ = 1;
	localparam int F_RXF   = 2;
	localparam int F_ADDR  = 3;
	localparam int F_NACK  = 4;
	localparam int F_STOP  = 5;
	localparam int F_XFER  = 6;
	localparam int F_RLD   = 7;
	localparam int F_BUS_ERR  = 8;
	localparam int F_ARB   = 9;
	localparam int F_OVR   = 10;
	localparam int F_CRCE  = 11;
	localparam int F_TMO   = 12;
	localparam int F_ALERT = 13;

	// Control and address-mask register field positions.
	localparam int C_START = 8;
	localparam int C_STOP  = 9;
	localparam int C_OWNEN = 10;
	localparam int C_BCNT  = 16;
	localparam int C_OWN   = 25;
	localparam int M_POS   = 9;

	// Reset values, flag groups and checksum polynomial.
	localparam logic [13:0] FLAGS_RST = 14'h0001;
	localparam logic [13:0] CLR_MASK  = 14'h3F38;
	localparam logic [7:0]  CRC_POLY  = 8'h07;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_RX   = 2'b10,
		ST_TX   = 2'b11
	} link_st_t;

	typedef struct packed {
		logic        unit_en;
		logic        master;
		logic        reload;
		logic        auto_stop;
		logic        pec_en;
		logic        tx_irq_en;
		logic        tx_dma_en;
		logic        stretch_dis;
		logic        own_en;
		logic [7:0]  byte_count;
		logic [6:0]  own_addr;
		logic [6:0]  addr_mask;
		logic [13:0] flags;
		logic [13:0] irq_st;
		logic [13:0] irq_mask;
		logic        busy;
		logic        tr;
		logic [6:0]  match_addr;
		logic [7:0]  crc;
		logic [7:0]  rx_data;
		logic [7:0]  tx_data;
		logic [7:0]  tx_sh;
		logic [7:0]  sh;
		logic [7:0]  byte_cnt;
		link_st_t    st;
		logic [3:0]  bit_cnt;
		logic        ack_pend;
		logic [2:0]  scl_sy;
		logic [2:0]  sda_sy;
		logic        sda_o;
		logic        sda_oe;
		logic        irq;
		logic        tx_irq_req;
		logic        tx_dma_req;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} state_t;

endpackage : i2c_status_pkg

// >>> rtl/i2c_status_data_regs.sv
// Status flags, flag clear, checksum, data and address-mask registers of a two-wire bus unit,
// with a small slave byte engine that produces the events behind the flags.
// Assumes an APB master on core_clk and bus pins that arrive asynchronously.
// The slave engine never stretches the clock; software must keep the transmit register filled.
//
// Our own choice: the APB register port.
module i2c_status_data_regs
	import i2c_status_pkg::*;
(
	input  wire logic        core_clk,     // Block clock, 50 MHz.
	input  wire logic        rst_n,        // Asynchronous reset, active low.
	input  wire logic        psel,         // APB select.
	input  wire logic        penable,      // APB access phase.
	input  wire logic        pwrite,       // APB write when high.
	input  wire logic [11:0] paddr,        // APB byte address.
	input  wire logic [31:0] pwdata,       // APB write data.
	output logic      [31:0] prdata,       // APB read data.
	output logic             pready,       // APB ready.
	output logic             pslverr,      // APB error on unmapped address.
	input  wire logic        scl_in,       // Bus clock line level.
	input  wire logic        sda_in,       // Bus data line level.
	output logic             sda_out,      // Data line drive value, always low.
	output logic             sda_oe,       // High while the data line is pulled low.
	input  wire logic        alert_evt,    // Alert event pulse from sibling logic.
	input  wire logic        timeout_evt,  // Timeout event pulse.
	input  wire logic        arb_lost_evt, // Arbitration lost pulse.
	input  wire logic        crc_err_evt,  // Checksum mismatch pulse.
	output logic             irq,          // Level interrupt.
	output logic             tx_irq_req,   // Transmit interrupt request.
	output logic             tx_dma_req    // Transmit DMA request.
);

	// Registered state and the next value built for it. Keeping every flop in one struct means the
	// reset branch and the register update cannot drift apart as fields are added.
	state_t      s;
	state_t      n;
	// Events of the current cycle; they are merged into the flags after every clear has been applied.
	logic [13:0] ev;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        hit;
	logic [31:0] rdv;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	logic        moved;
	logic [7:0]  b;
	logic [7:0]  cnt_inc;

	// One step of the checksum over a whole byte, polynomial x^8+x^2+x+1.
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc8

	// Own-address compare where a zero mask bit makes the bit a don't-care.
	function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] own, input logic [6:0] m);
		return ((a ^ own) & m) == 7'h00;
	endfunction : addr_hit

	// A start or stop is misplaced once a byte has passed its first bit. Every stop and repeated start
	// is preceded by a clock rise that the engine counts as a first bit, so one counted bit is still
	// a legal frame boundary and must not be reported as a bus error.
	function automatic logic mid_byte(input link_st_t st, input logic [3:0] cnt);
		return (st != ST_IDLE) && (cnt > 4'h1);
	endfunction : mid_byte

	// Read multiplexer and address decode, sampled during the setup phase.
	// Unused offsets and anything above the low page decode as a miss, which the bus port answers
	// with an error and zero data rather than an alias of another register.
	always_comb begin
		hit = 1'b1;
		rdv = 32'h0000_0000;
		if (paddr[11:8] != 4'h0) begin
			hit = 1'b0;
		end else begin
			unique case (paddr[7:0])
				OFF_CTRL: begin
					rdv = {s.own_addr, 1'b0, s.byte_count, 5'h00, s.own_en, 2'b00, s.stretch_dis, s.tx_dma_en,
						s.tx_irq_en, s.pec_en, s.auto_stop, s.reload, s.master, s.unit_en};
				end
				OFF_STATUS: begin
					rdv = {8'h00, s.match_addr, s.tr, s.busy, 1'b0, s.flags};
				end
				OFF_CLEAR: begin
					rdv = 32'h0000_0000;
				end
				OFF_CRC: begin
					rdv = {24'h000000, s.crc};
				end
				OFF_RXDATA: begin
					rdv = {24'h000000, s.rx_data};
				end
				OFF_TXDATA: begin
					rdv = {24'h000000, s.tx_data};
				end
				OFF_IRQ_ST: begin
					rdv = {18'h00000, s.irq_st};
				end
				OFF_IRQ_MASK: begin
					rdv = {18'h00000, s.irq_mask};
				end
				OFF_ADDRMASK: begin
					rdv = {16'h0000, s.addr_mask, 9'h000};
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end
	end

	// Next-state logic: bus slave first, then the link engine, so hardware sets win over clears.
	always_comb begin
		n = s;
		ev = 14'h0000;
		moved = 1'b0;
		b = {s.sh[6:0], s.sda_sy[1]};
		cnt_inc = s.byte_cnt + 8'h01;

		// Two-flop synchronisers; bit 2 keeps the previous synchronised level for edge finding.
		// Only the second and third stages are read by logic, so the first has a full clock period to settle.
		n.scl_sy = {s.scl_sy[1:0], scl_in};
		n.sda_sy = {s.sda_sy[1:0], sda_in};
		scl_rise = s.scl_sy[1] & ~s.scl_sy[2];
		scl_fall = ~s.scl_sy[1] & s.scl_sy[2];
		start_c = s.scl_sy[1] & s.scl_sy[2] & s.sda_sy[2] & ~s.sda_sy[1];
		stop_c = s.scl_sy[1] & s.scl_sy[2] & ~s.sda_sy[2] & s.sda_sy[1];

		// Zero-wait APB: ready and data are registered in the setup cycle.
		// Read data is frozen at the setup edge, so a flag that sets during the access phase is not
		// lost: it stays set and shows on the next read instead.
		acc = psel & penable & s.pready;
		wr = acc & pwrite;
		rd = acc & ~pwrite;
		n.pready = psel & ~penable;
		n.pslverr = psel & ~penable & ~hit;
		n.prdata = (psel & ~penable & ~pwrite) ? rdv : 32'h0000_0000;

		// Read side effects clear only what the reader was actually shown.
		if (rd && paddr[7:0] == OFF_RXDATA && hit) begin
			n.flags[F_RXF] = 1'b0;
		end
		if (rd && paddr[7:0] == OFF_IRQ_ST && hit) begin
			n.irq_st = s.irq_st & ~s.prdata[13:0];
		end

		// Register writes; word accesses are assumed, byte lanes are not decoded.
		// A narrow write from software would therefore still touch every field of the word.
		if (wr && hit) begin
			unique case (paddr[7:0])
				OFF_CTRL: begin
					n.unit_en = pwdata[0];
					n.master = pwdata[1];
					n.reload = pwdata[2];
					n.auto_stop = pwdata[3];
					n.pec_en = pwdata[4];
					n.tx_irq_en = pwdata[5];
					n.tx_dma_en = pwdata[6];
					n.stretch_dis = pwdata[7];
					n.own_en = pwdata[C_OWNEN];
					n.byte_count = pwdata[C_BCNT +: 8];
					n.own_addr = pwdata[C_OWN +: 7];
					if (pwdata[C_START] || pwdata[C_STOP]) begin
						n.flags[F_XFER] = 1'b0;
					end
					if (pwdata[C_BCNT +: 8] != 8'h00) begin
						n.flags[F_RLD] = 1'b0;
						n.byte_cnt = 8'h00;
					end
				end
				OFF_STATUS: begin
					if (pwdata[F_TXE]) begin
						n.flags[F_TXE] = 1'b1;
					end
					if (pwdata[F_TXREQ] && s.stretch_dis) begin
						n.flags[F_TXREQ] = 1'b1;
					end
				end
				OFF_CLEAR: begin
					n.flags = n.flags & ~(pwdata[13:0] & CLR_MASK);
				end
				OFF_TXDATA: begin
					n.tx_data = pwdata[7:0];
					n.flags[F_TXE] = 1'b0;
					n.flags[F_TXREQ] = 1'b0;
				end
				OFF_IRQ_MASK: begin
					n.irq_mask = pwdata[13:0];
				end
				OFF_ADDRMASK: begin
					n.addr_mask = pwdata[M_POS +: 7];
				end
				default: begin
					n.irq_mask = n.irq_mask;
				end
			endcase
		end

		if (!s.unit_en) begin
			// A disabled unit drops its error and event flags, checksum and link state.
			// The bus is ignored entirely here, so a frame that is cut by disabling ends without a stop
			// and the next frame is only recognised from its start condition.
			n.flags = n.flags & ~CLR_MASK;
			n.crc = 8'h00;
			n.st = ST_IDLE;
			n.bit_cnt = 4'h0;
			n.ack_pend = 1'b0;
			n.busy = 1'b0;
			n.sda_oe = 1'b0;
			n.byte_cnt = 8'h00;
		end else begin
			ev[F_ALERT] = alert_evt;
			ev[F_TMO] = timeout_evt;
			ev[F_ARB] = arb_lost_evt;
			ev[F_CRCE] = crc_err_evt;
			if (start_c) begin
				// A start in the middle of a byte is a misplaced condition.
				ev[F_BUS_ERR] = mid_byte(s.st, s.bit_cnt);
				n.st = ST_ADDR;
				n.bit_cnt = 4'h0;
				n.busy = 1'b1;
				n.sda_oe = 1'b0;
				n.ack_pend = 1'b0;
			end else if (stop_c) begin
				ev[F_STOP] = 1'b1;
				ev[F_BUS_ERR] = mid_byte(s.st, s.bit_cnt);
				n.st = ST_IDLE;
				n.busy = 1'b0;
				n.sda_oe = 1'b0;
			end else if (scl_rise && s.st != ST_IDLE) begin
				// Data is taken on the rising clock, where the far side must hold it stable; the
				// transmit shifter advances here so that the next bit is ready for the fall.
				if (s.bit_cnt < 4'h8) begin
					n.sh = b;
					n.tx_sh = {s.tx_sh[6:0], 1'b1};
					n.bit_cnt = s.bit_cnt + 4'h1;
					if (s.bit_cnt == 4'h7) begin
						unique case (s.st)
							// The address byte is only acknowledged when it matches; otherwise the
							// engine leaves the frame and ignores the clock until the next start; a stop is still flagged.
							ST_ADDR: begin
								if (s.own_en && addr_hit(b[7:1], s.own_addr, s.addr_mask)) begin
									ev[F_ADDR] = 1'b1;
									n.match_addr = b[7:1];
									n.tr = b[0];
									n.ack_pend = 1'b1;
								end else begin
									n.st = ST_IDLE;
								end
							end
							ST_RX: begin
								// A byte arriving over an unread one is kept out and flagged.
								if (s.flags[F_RXF]) begin
									ev[F_OVR] = 1'b1;
								end else begin
									n.rx_data = b;
									ev[F_RXF] = 1'b1;
								end
								n.ack_pend = 1'b1;
								moved = 1'b1;
							end
							default: begin
								n.ack_pend = 1'b0;
								moved = 1'b1;
							end
						endcase
					end
				end else if (s.bit_cnt == 4'h8) begin
					// The acknowledge bit: a high line while sending is a refusal.
					// After a refusal the engine drops out of the frame and waits for the next start.
					if (s.st == ST_TX && s.sda_sy[1]) begin
						ev[F_NACK] = 1'b1;
						n.st = ST_IDLE;
						n.sda_oe = 1'b0;
					end
					n.bit_cnt = 4'h9;
				end
			end else if (scl_fall && s.st != ST_IDLE) begin
				// The fall after the acknowledge opens the next byte: the direction taken from the
				// address byte decides whether the shifter is loaded for sending.
				if (s.bit_cnt == 4'h9) begin
					n.bit_cnt = 4'h0;
					n.ack_pend = 1'b0;
					n.sda_oe = 1'b0;
					if (s.st == ST_ADDR) begin
						n.st = s.tr ? ST_TX : ST_RX;
					end
					if (n.st == ST_TX) begin
						// No stretching here: an empty transmit register is an underrun.
						ev[F_OVR] = s.flags[F_TXE];
						n.tx_sh = s.tx_data;
						n.sda_oe = ~s.tx_data[7];
						ev[F_TXE] = 1'b1;
						ev[F_TXREQ] = 1'b1;
					end
				end else if (s.bit_cnt == 4'h8) begin
					n.sda_oe = s.ack_pend;
				end else if (s.st == ST_TX) begin
					n.sda_oe = ~s.tx_sh[7];
				end
			end
			// A whole data byte has passed: fold it into the checksum and advance the byte counter. The
			// counter wraps at the programmed count, so a reload sequence runs without software
			// rewinding it, and a count of zero never completes.
			if (moved) begin
				if (s.pec_en) begin
					n.crc = crc8(s.crc, b);
				end
				n.byte_cnt = cnt_inc;
				if (s.byte_count != 8'h00 && cnt_inc == s.byte_count) begin
					n.byte_cnt = 8'h00;
					if (s.reload) begin
						ev[F_RLD] = 1'b1;
					end else if (s.master && !s.auto_stop) begin
						ev[F_XFER] = 1'b1;
					end
				end
			end
		end

		// Sticky flags and interrupt status; sets are applied last and win.
		// An event that lands in the same cycle as a software clear is therefore never lost, at the
		// price of the clear appearing to have no effect for that one event.
		n.flags = n.flags | ev;
		n.irq_st = n.irq_st | ev;
		n.irq = |(n.irq_st & n.irq_mask);
		n.tx_irq_req = n.flags[F_TXREQ] & n.tx_irq_en;
		n.tx_dma_req = n.flags[F_TXREQ] & n.tx_dma_en;
		n.sda_o = 1'b0;
	end

	// State register; the transmit register starts empty.
	// The bus synchronisers reset to the idle high level so no false edge appears at release.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.flags <= FLAGS_RST;
			s.scl_sy <= 3'h7;
			s.sda_sy <= 3'h7;
		end else begin
			s <= n;
		end
	end

	// Outputs come straight from the state flops.
	// No output is decoded combinationally, so the bus port and the link see glitch-free levels.
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign sda_out = s.sda_o;
	assign sda_oe = s.sda_oe;
	assign irq = s.irq;
	assign tx_irq_req = s.tx_irq_req;
	assign tx_dma_req = s.tx_dma_req;

endmodule : i2c_status_data_regs

// >>> verification/i2c_status_data_regs_asserts.sv
// Checker of the register port and transmit request outputs.
// Assumes it is bound to the block and sees only its ports.
module i2c_status_data_regs_asserts
	import i2c_status_pkg::*;
(
	input wire logic        core_clk,   // Clock.
	input wire logic        rst_n,      // Reset, active low.
	input wire logic        psel,       // Select.
	input wire logic        penable,    // Access phase.
	input wire logic        pwrite,     // Write.
	input wire logic [11:0] paddr,      // Address.
	input wire logic [31:0] pwdata,     // Write data.
	input wire logic [31:0] prdata,     // Read data.
	input wire logic        pready,     // Ready.
	input wire logic        pslverr,    // Error.
	input wire logic        sda_out,    // Data line drive value.
	input wire logic        tx_irq_req, // Transmit irq.
	input wire logic        tx_dma_req  // Transmit DMA.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic en_ff;
	logic nxt_en;
	logic rd;
	// Mirror of the enable bit, so flag reads can be judged while disabled.
	always_comb begin
		nxt_en = en_ff;
		if (psel && penable && pready && pwrite && paddr == {4'h0, OFF_CTRL})
			nxt_en = pwdata[0];
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			en_ff <= 1'b0;
		else
			en_ff <= nxt_en;
	end
	assign rd = pready && !pwrite;
	answer_one_a: assert property (psel && !penable |=> pready)
		else $error("Setup not answered.");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("Ready outside access.");
	unmapped_err_a: assert property (pready && paddr[11:8] != 4'h0 |-> pslverr && prdata == 32'h0)
		else $error("Unmapped access not refused.");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("Read data outside access.");
	byte_regs_a: assert property (rd && paddr[7:4] == 4'h2 |-> prdata[31:8] == 24'h0)
		else $error("Upper byte lanes not zero.");
	tx_clear_a: assert property (pready && pwrite && paddr == {4'h0, OFF_TXDATA} |-> ##2 !tx_irq_req && !tx_dma_req)
		else $error("Transmit request kept after write.");
	off_flags_a: assert property (rd && paddr == {4'h0, OFF_STATUS} && !en_ff |-> prdata[5:3] == 3'h0)
		else $error("Flags kept while disabled.");
	off_crc_a: assert property (rd && paddr == {4'h0, OFF_CRC} && !en_ff |-> prdata == 32'h0)
		else $error("Checksum kept while disabled.");
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("Data line driven high.");
endmodule : i2c_status_data_regs_asserts

bind i2c_status_data_regs i2c_status_data_regs_asserts i2c_status_data_regs_asserts_inst (.core_clk, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sda_out, .tx_irq_req, .tx_dma_req);

// >>> verification/i2c_bus_master_model.sv
// Behavioural bus master on the far side of the two-wire port.
// Assumes the bench resolves the data line with a pull-up into sda.
module i2c_bus_master_model (
	output logic      scl,    // Bus clock, high between frames.
	output logic      sda_lo, // High while pulling data low.
	input  wire logic sda     // Resolved data line.
);
	timeunit 1ns;
	timeprecision 1ns;
	// Both lines idle high; the clock moves only inside a frame.
	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end
	// Data falls while the clock is high; a spare low phase keeps the first bit clear of it.
	task start;
		#40 sda_lo = 1'b1;
		#40 scl = 1'b0;
		#40;
	endtask
	// A 160 ns slot: data moves only while the clock is low, read mid-high.
	task bit_io(input logic b, output logic v);
		sda_lo = !b;
		#40 scl = 1'b1;
		#40 v = sda;
		#40 scl = 1'b0;
		#40;
	endtask
	// Byte MSB first, then the ninth slot; a one there releases data for the other side.
	task xfer(input logic [7:0] d, input logic am, output logic [7:0] v, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], v[i]);
		bit_io(am, k);
	endtask
	// Data rises while the clock is high.
	task stop;
		sda_lo = 1'b1;
		#40 scl = 1'b1;
		#40 sda_lo = 1'b0;
		#80;
	endtask
endmodule : i2c_bus_master_model

// >>> verification/test_i2c_status_data_regs.sv
// Self-checking bench of the two-wire status and data register block.
// Assumes the package, the block, the bus master model and the checker are compiled first.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_i2c_status_data_regs;
	import i2c_status_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [31:0] m;} row_t;
	localparam row_t ROWS [12] = '{'{0, OFF_STATUS, '0, 1, '1}, '{0, OFF_CRC, '0, '0, '1},
		'{0, OFF_RXDATA, '0, '0, '1}, '{0, OFF_TXDATA, '0, '0, '1}, '{0, OFF_ADDRMASK, '0, '0, '1},
		'{1, OFF_TXDATA, 'hA5, '0, '0}, '{0, OFF_TXDATA, '0, 'hA5, '1}, '{0, OFF_STATUS, '0, '0, 1},
		'{1, OFF_STATUS, 1, '0, '0}, '{0, OFF_STATUS, '0, 1, 1},
		'{1, OFF_ADDRMASK, '1, '0, '0}, '{0, OFF_ADDRMASK, '0, 'hFE00, '1}};
	logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic        pready, pslverr, sda_out, sda_oe, irq, tx_irq_req, tx_dma_req, scl, sda_lo, ack;
	logic [3:0]  ev = '0;
	logic [7:0]  q, crc = '0;
	int          num_errors = 0, n_compared = 0;
	wire logic   sda_in = !(sda_lo | sda_oe);
	i2c_status_data_regs i2c_status_data_regs_inst (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in, .sda_out, .sda_oe, .alert_evt(ev[3]),
		.timeout_evt(ev[2]), .arb_lost_evt(ev[1]), .crc_err_evt(ev[0]), .irq, .tx_irq_req, .tx_dma_req);
	i2c_bus_master_model i2c_bus_master_model_inst (.scl, .sda_lo, .sda(sda_in));
	// Whole-word transfer; the request holds until ready is seen, a lost answer counts as a mismatch.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] v);
		int t;
		t = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (t >= 20)
			num_errors++;
		v = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, {4'h0, a}, d, r);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, {4'h0, a}, 32'h0, r);
		`CHK(r & m, e)
	endtask
	task automatic bx(input logic [7:0] d);
		i2c_bus_master_model_inst.xfer(d, 1'b1, q, ack);
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge core_clk);
		ev <= v;
		@(posedge core_clk);
		ev <= 4'h0;
		repeat (3) @(posedge core_clk);
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
		return c;
	endfunction
	task end_of_test;
		$display("Mismatches %0d, comparisons %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Clock of 20 ns.
	always #10 core_clk = ~core_clk;
	// A hang is cut short well past the expected run time.
	initial begin
		#1500000;
		num_errors++;
		end_of_test();
	end
	// Table first, then link traffic, interrupts, disable and a second reset.
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (ROWS[i]) begin
			apb(ROWS[i].w, {4'h0, ROWS[i].a}, ROWS[i].d, r);
			if (!ROWS[i].w)
				`CHK(r & ROWS[i].m, ROWS[i].e)
		end
		wr(OFF_CTRL, 32'h7401_0475);
		i2c_bus_master_model_inst.start();
		bx(8'h74);
		`CHK(ack, 1'b0)
		bx(8'h5C);
		`CHK(ack, 1'b0)
		i2c_bus_master_model_inst.stop();
		crc = crc8(crc, 8'h5C);
		rc(OFF_STATUS, 32'h0074_00AC, 32'h00FF_01BC);
		rc(OFF_CRC, {24'h0, crc}, '1);
		rc(OFF_RXDATA, 32'h5C, '1);
		rc(OFF_STATUS, 32'h0, 32'h4);
		wr(OFF_CTRL, 32'h7401_0475);
		rc(OFF_STATUS, 32'h0, 32'h80);
		wr(OFF_CLEAR, 32'h0);
		rc(OFF_STATUS, 32'h28, 32'h38);
		wr(OFF_CLEAR, 32'h38);
		rc(OFF_STATUS, 32'h0, 32'h38);
		wr(OFF_ADDRMASK, 32'hFC00);
		i2c_bus_master_model_inst.start();
		bx(8'h76);
		`CHK(ack, 1'b0)
		i2c_bus_master_model_inst.stop();
		wr(OFF_CLEAR, 32'h38);
		wr(OFF_ADDRMASK, 32'hFE00);
		i2c_bus_master_model_inst.start();
		bx(8'h76);
		`CHK(ack, 1'b1)
		i2c_bus_master_model_inst.stop();
		rc(OFF_STATUS, 32'h0, 32'h8);
		wr(OFF_TXDATA, 32'h96);
		i2c_bus_master_model_inst.start();
		bx(8'h75);
		`CHK(ack, 1'b0)
		bx(8'hFF);
		`CHK(q, 8'h96)
		i2c_bus_master_model_inst.stop();
		crc = crc8(crc, 8'h96);
		`CHK({tx_irq_req, tx_dma_req}, 2'b11)
		rc(OFF_STATUS, 32'h0001_003B, 32'h0001_003B);
		rc(OFF_CRC, {24'h0, crc}, '1);
		wr(OFF_CTRL, 32'h7401_0463);
		i2c_bus_master_model_inst.start();
		bx(8'h74);
		bx(8'h3C);
		i2c_bus_master_model_inst.stop();
		rc(OFF_STATUS, 32'h40, 32'hC0);
		wr(OFF_CTRL, 32'h7401_0563);
		rc(OFF_STATUS, 32'h0, 32'h40);
		wr(OFF_TXDATA, 32'h11);
		@(posedge core_clk);
		`CHK({tx_irq_req, tx_dma_req}, 2'b00)
		rc(OFF_STATUS, 32'h0, 32'h3);
		wr(OFF_STATUS, 32'h2);
		rc(OFF_STATUS, 32'h0, 32'h2);
		wr(OFF_CTRL, 32'h7401_04F5);
		wr(OFF_STATUS, 32'h2);
		rc(OFF_STATUS, 32'h2, 32'h2);
		wr(OFF_IRQ_MASK, 32'h2000);
		pulse(4'hF);
		`CHK(irq, 1'b1)
		rc(OFF_IRQ_ST, 32'h3A00, 32'h3A00);
		repeat (2) @(posedge core_clk);
		`CHK(irq, 1'b0)
		pulse(4'h4);
		`CHK(irq, 1'b0)
		rc(OFF_STATUS, 32'h3A00, 32'h3A00);
		wr(OFF_CLEAR, 32'h3A00);
		rc(OFF_STATUS, 32'h0, 32'h3B00);
		wr(OFF_CTRL, 32'h0);
		rc(OFF_STATUS, 32'h0, 32'h38);
		rc(OFF_CRC, 32'h0, '1);
		apb(1'b0, 12'h100, 32'h0, r);
		`CHK(r, 32'h0)
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rc(OFF_STATUS, 32'h1, '1);
		end_of_test();
	end
endmodule : test_i2c_status_data_regs
